/* File: scsr_pkg.sv */
// Constants, field layout and types of the switch configuration serial port.
// Assumes a 16-bit frame: watchdog bit, five address bits, normal-flag bit, nine data bits.
// Summary of operation
// - Profile register kept per output, frame selects
// - Bit D8 set disables lamp overcurrent profile
// - D7:D6 cooling speed: medium, slow, fast, medium
// - D5:D4 inrush speed: slow, fast, medium, very slow
// - D3 set uses second high limit initially
// - D2:D1 steady limit: two, three, four, one
// - D0 zero inrush only, one adds cooling
// - Supply fail with detector on forces fail-safe
// - Modulation enabled drives outputs from duty register
// - D7 zero disables modulation; D6 picks clock
// - D5:D4 feedback: off, current copy, temperature
// - D3:D2 code 10 first, 11 second output
// - Global D0 set disables overvoltage protection
// - Chip select fall loads, shifts out MSB first
// - First sixteen bits come from previous frame
// - Later bits echo serial input for chaining
// - Latch only on nonzero multiple of sixteen bits
// - After select rises: tri-state, faults captured again
// - Last status command chooses readback and output
// - Readback selection persists until next status command
// - Invalid frame leaves selection and registers unchanged
// - Address bits D14:D10 choose target register
// - D13 zero first output, one second output
// - Returned bits: watchdog, select bits, normal flag
package scsr_pkg;
	localparam int          FRAME_BITS   = 16;
	localparam int          DATA_BITS    = 9;
	localparam int          WATCHDOG_BIT = 15;
	localparam int          ADDR_HI      = 14;
	localparam int          ADDR_LO      = 10;
	localparam int          OUT_SEL_BIT  = 13;
	localparam int          NORMAL_BIT   = 9;
	localparam logic [2:0]  STATUS_SUB   = 3'h0;
	localparam logic [2:0]  PROFILE_SUB  = 3'h4;
	localparam logic [4:0]  GLOBAL_ADDR  = 5'h05;
	localparam logic [4:0]  TRIM_ADDR    = 5'h07;
	localparam int          RB_BITS      = 5;
	localparam int          RB_LONG_BIT  = 4;
	localparam int          RB_OUT_BIT   = 3;
	localparam logic [2:0]  RB_FAULT     = 3'h0;
	localparam logic [2:0]  RB_PROFILE   = 3'h4;
	localparam logic [4:0]  RB_GLOBAL    = 5'h05;
	// Overcurrent profile fields
	localparam int          LAMP_OFF_BIT         = 8;
	localparam int          COOLING_CURVE_HI     = 7;
	localparam int          COOLING_CURVE_LO     = 6;
	localparam int          INRUSH_CURVE_HI      = 5;
	localparam int          INRUSH_CURVE_LO      = 4;
	localparam int          HIGH_LEVEL_OVERRIDE  = 3;
	localparam int          STEADY_SEL_HI        = 2;
	localparam int          STEADY_SEL_LO        = 1;
	localparam int          COOLING_MGMT_SELECT  = 0;
	// Global configuration fields
	localparam int          SUPPLY_FAIL_EN       = 8;
	localparam int          MODULATION_EN        = 7;
	localparam int          CLOCK_SOURCE_SEL     = 6;
	localparam int          TEMP_FEEDBACK_EN     = 5;
	localparam int          CURRENT_FEEDBACK_ON  = 4;
	localparam int          FEEDBACK_OUTPUT_SEL_HI = 3;
	localparam int          FEEDBACK_OUTPUT_SEL_LO = 2;
	localparam int          OVERVOLTAGE_GUARD_OFF  = 0;
	localparam logic [8:0]  GLOBAL_READ_MASK     = 9'h1fd;
	// Reset values
	localparam logic [8:0]  PROFILE_RST  = 9'h000;
	localparam logic [8:0]  GLOBAL_RST   = 9'h000;
	localparam logic [8:0]  TRIM_RST     = 9'h000;
	localparam logic [4:0]  RB_SEL_RST   = 5'h00;
	// Steady-state limit codes: index of the level minus one
	localparam logic [1:0]  LIMIT_ONE    = 2'h0;
	localparam logic [1:0]  LIMIT_TWO    = 2'h1;
	localparam logic [1:0]  LIMIT_THREE  = 2'h2;
	localparam logic [1:0]  LIMIT_FOUR   = 2'h3;

	typedef enum logic [1:0] {
		SPEED_SLOW,
		SPEED_MEDIUM,
		SPEED_FAST,
		SPEED_VERY_SLOW
	} scsr_speed_t;
endpackage

/* File: scsr_sync.sv */
// Two-flop synchroniser, one per bit, for pins entering the clk domain.
// Assumes inputs are quasi-static or slow against clk.
`timescale 1ns/10ps
`default_nettype none
module scsr_sync #(
	parameter int               W   = 1,
	parameter logic [W-1:0]     RST = '0
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           rst,
	// Data
	input  wire logic [W-1:0]   pinIn,
	output logic      [W-1:0]   syncOut
);
	logic [W-1:0] meta_q;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				meta_q[i]  <= RST[i];
				syncOut[i] <= RST[i];
			end else begin
				meta_q[i]  <= pinIn[i];
				syncOut[i] <= meta_q[i];
			end
		end
	end
endmodule
`default_nettype wire

/* File: scsr_profile_decode.sv */
// Decodes one output's overcurrent profile register into settings.
// Assumes the register value is held in flops by the caller.
`timescale 1ns/10ps
`default_nettype none
module scsr_profile_decode (
	// Stored profile
	input  wire logic [8:0]          profile,
	// Decoded settings
	output logic                     lampProfileOff,
	output scsr_pkg::scsr_speed_t    coolingSpeed,
	output scsr_pkg::scsr_speed_t    inrushSpeed,
	output logic                     highLevelOverride,
	output logic [1:0]               steadyLimit,
	output logic                     coolingManagementSelect
);
	logic [1:0] coolCode;
	logic [1:0] inrushCode;
	logic [1:0] steadyCode;

	assign coolCode   = {profile[scsr_pkg::COOLING_CURVE_HI], profile[scsr_pkg::COOLING_CURVE_LO]};
	assign inrushCode = {profile[scsr_pkg::INRUSH_CURVE_HI], profile[scsr_pkg::INRUSH_CURVE_LO]};
	assign steadyCode = {profile[scsr_pkg::STEADY_SEL_HI], profile[scsr_pkg::STEADY_SEL_LO]};
	assign lampProfileOff          = profile[scsr_pkg::LAMP_OFF_BIT];
	assign highLevelOverride       = profile[scsr_pkg::HIGH_LEVEL_OVERRIDE];
	assign coolingManagementSelect = profile[scsr_pkg::COOLING_MGMT_SELECT];

	always_comb begin
		case (coolCode)
			2'h1:    coolingSpeed = scsr_pkg::SPEED_SLOW;
			2'h2:    coolingSpeed = scsr_pkg::SPEED_FAST;
			default: coolingSpeed = scsr_pkg::SPEED_MEDIUM;
		endcase
		case (inrushCode)
			2'h1:    inrushSpeed = scsr_pkg::SPEED_FAST;
			2'h2:    inrushSpeed = scsr_pkg::SPEED_MEDIUM;
			2'h3:    inrushSpeed = scsr_pkg::SPEED_VERY_SLOW;
			default: inrushSpeed = scsr_pkg::SPEED_SLOW;
		endcase
		case (steadyCode)
			2'h1:    steadyLimit = scsr_pkg::LIMIT_THREE;
			2'h2:    steadyLimit = scsr_pkg::LIMIT_FOUR;
			2'h3:    steadyLimit = scsr_pkg::LIMIT_ONE;
			default: steadyLimit = scsr_pkg::LIMIT_TWO;
		endcase
	end
endmodule
`default_nettype wire

/* File: scsr_spi_readback.sv */
// Serial configuration slave with readback for a dual high-side switch.
// Assumes clock idles low; SI sampled on rising, SO moved on falling edge.
`timescale 1ns/10ps
`default_nettype none
module scsr_spi_readback (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// Serial pins
	input  wire logic                        chipSelectN,
	input  wire logic                        spiClk,
	input  wire logic                        serialIn,
	output logic                             serialOut,
	output logic                             serialOutOe,
	// Device status and controls
	input  wire logic [1:0][7:0]             faultFlags,
	input  wire logic [1:0]                  dutyOn,
	input  wire logic [1:0]                  directIn,
	input  wire logic                        supplyLow,
	// Switch drive
	output logic [1:0]                       switchOn,
	output logic                             failSafe,
	// Per-output profile settings
	output logic [1:0]                       lampProfileOff,
	output scsr_pkg::scsr_speed_t [1:0]      coolingSpeed,
	output scsr_pkg::scsr_speed_t [1:0]      inrushSpeed,
	output logic [1:0]                       highLevelOverride,
	output logic [1:0][1:0]                  steadyLimit,
	output logic [1:0]                       coolingManagementSelect,
	// Global settings
	output logic                             modulationOn,
	output logic                             modulationInternalClk,
	output logic                             feedbackTristate,
	output logic                             feedbackCurrent,
	output logic                             feedbackTemp,
	output logic                             feedbackSelValid,
	output logic                             feedbackOutputSel,
	output logic                             overvoltageGuardOn,
	output logic [8:0]                       oscillatorTrim
);
	typedef struct packed {
		logic              csnD;
		logic              sclkD;
		logic              siBit;
		logic              oe;
		logic [15:0]       shift;
		logic [3:0]        cnt;
		logic              seen;
		logic [1:0][8:0]   prof;
		logic [8:0]        glob;
		logic [8:0]        trim;
		logic [4:0]        sel;
		logic              wd;
		logic [1:0][7:0]   fault;
		logic [1:0]        sw;
	} scsr_state_t;

	localparam scsr_state_t ST_RST = '{
		csnD:  1'b1,
		prof:  {2{scsr_pkg::PROFILE_RST}},
		glob:  scsr_pkg::GLOBAL_RST,
		trim:  scsr_pkg::TRIM_RST,
		sel:   scsr_pkg::RB_SEL_RST,
		default: '0
	};

	scsr_state_t st_q;
	scsr_state_t st_d;
	logic [5:0]  pinS;
	logic        analog_feedback_pin;
	logic        sclkS;
	logic        siS;
	logic        lowS;
	logic [1:0]  dirS;
	logic        csFall;
	logic        csRise;
	logic        sclkRise;
	logic        sclkFall;
	logic        frameOk;
	logic        dutyDrive;
	logic [4:0]  frameAddr;
	logic [8:0]  payload;
	logic [15:0] outWord;

	scsr_sync #(
		.W   (6),
		.RST (6'h20)
	) u_sync (
		.clk     (clk),
		.rst     (rst),
		.pinIn   ({chipSelectN, spiClk, serialIn, supplyLow, directIn}),
		.syncOut (pinS)
	);

	assign {analog_feedback_pin, sclkS, siS, lowS, dirS} = pinS;

	assign csFall   = st_q.csnD & ~analog_feedback_pin;
	assign csRise   = ~st_q.csnD & analog_feedback_pin;
	assign sclkRise = ~st_q.sclkD & sclkS & ~analog_feedback_pin;
	assign sclkFall = st_q.sclkD & ~sclkS & ~analog_feedback_pin;
	assign frameOk  = st_q.seen & (st_q.cnt == 4'h0);
	assign frameAddr = st_q.shift[scsr_pkg::ADDR_HI:scsr_pkg::ADDR_LO];

	// Readback word built from stored selection and registers
	always_comb begin
		payload = '0;
		if (st_q.sel[scsr_pkg::RB_LONG_BIT] && st_q.sel[2:0] == scsr_pkg::RB_FAULT) begin
			payload = {1'b0, st_q.fault[st_q.sel[scsr_pkg::RB_OUT_BIT]]};
		end else if (st_q.sel[scsr_pkg::RB_LONG_BIT] && st_q.sel[2:0] == scsr_pkg::RB_PROFILE) begin
			payload = st_q.prof[st_q.sel[scsr_pkg::RB_OUT_BIT]];
		end else if (st_q.sel == scsr_pkg::RB_GLOBAL) begin
			payload = st_q.glob & scsr_pkg::GLOBAL_READ_MASK;
		end
		outWord = {st_q.wd, st_q.sel, 1'b1, payload};
	end

	assign failSafe  = st_q.glob[scsr_pkg::SUPPLY_FAIL_EN] & lowS;
	assign dutyDrive = st_q.glob[scsr_pkg::MODULATION_EN] | failSafe;

	always_comb begin
		st_d       = st_q;
		st_d.csnD  = analog_feedback_pin;
		st_d.sclkD = sclkS;
		// Faults frozen while a frame is open
		if (analog_feedback_pin) begin
			st_d.fault = faultFlags;
		end
		for (int i = 0; i < 2; i++) begin
			st_d.sw[i] = dutyDrive ? dutyOn[i] : dirS[i];
		end
		if (csFall) begin
			st_d.shift = outWord;
			st_d.cnt   = '0;
			st_d.seen  = 1'b0;
			st_d.oe    = 1'b1;
		end else if (sclkRise) begin
			st_d.siBit = siS;
			st_d.cnt   = st_q.cnt + 4'h1;
			st_d.seen  = 1'b1;
		end else if (sclkFall) begin
			st_d.shift = {st_q.shift[14:0], st_q.siBit};
		end
		if (csRise) begin
			st_d.oe = 1'b0;
			if (frameOk) begin
				st_d.wd = st_q.shift[scsr_pkg::WATCHDOG_BIT];
				if (frameAddr[2:0] == scsr_pkg::STATUS_SUB) begin
					st_d.sel = st_q.shift[scsr_pkg::RB_BITS-1:0];
				end else if (frameAddr[2:0] == scsr_pkg::PROFILE_SUB) begin
					st_d.prof[st_q.shift[scsr_pkg::OUT_SEL_BIT]] = st_q.shift[8:0];
				end else if (frameAddr == scsr_pkg::GLOBAL_ADDR) begin
					st_d.glob = st_q.shift[8:0];
				end else if (frameAddr == scsr_pkg::TRIM_ADDR) begin
					st_d.trim = st_q.shift[8:0];
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_out
		scsr_profile_decode u_dec (
			.profile                 (st_q.prof[g]),
			.lampProfileOff          (lampProfileOff[g]),
			.coolingSpeed            (coolingSpeed[g]),
			.inrushSpeed             (inrushSpeed[g]),
			.highLevelOverride       (highLevelOverride[g]),
			.steadyLimit             (steadyLimit[g]),
			.coolingManagementSelect (coolingManagementSelect[g])
		);
	end

	assign serialOut   = st_q.shift[scsr_pkg::FRAME_BITS-1];
	assign serialOutOe = st_q.oe;
	assign switchOn    = st_q.sw;
	assign oscillatorTrim = st_q.trim;
	assign modulationOn   = st_q.glob[scsr_pkg::MODULATION_EN];
	assign modulationInternalClk = st_q.glob[scsr_pkg::MODULATION_EN]
		& st_q.glob[scsr_pkg::CLOCK_SOURCE_SEL];
	assign feedbackCurrent  = st_q.glob[scsr_pkg::CURRENT_FEEDBACK_ON];
	assign feedbackTemp     = st_q.glob[scsr_pkg::TEMP_FEEDBACK_EN]
		& ~st_q.glob[scsr_pkg::CURRENT_FEEDBACK_ON];
	assign feedbackTristate = ~feedbackCurrent & ~feedbackTemp;
	assign feedbackSelValid  = st_q.glob[scsr_pkg::FEEDBACK_OUTPUT_SEL_HI];
	assign feedbackOutputSel = st_q.glob[scsr_pkg::FEEDBACK_OUTPUT_SEL_LO];
	assign overvoltageGuardOn = ~st_q.glob[scsr_pkg::OVERVOLTAGE_GUARD_OFF];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_loadOnFall;
		csFall |=> serialOutOe && st_q.shift == $past(outWord);
	endproperty
	a_loadOnFall: assert property (p_loadOnFall) else $error("word not loaded");

	property p_msbFirst;
		csFall |=> serialOut == $past(st_q.wd);
	endproperty
	a_msbFirst: assert property (p_msbFirst) else $error("msb not first");

	property p_echo;
		sclkFall |=> st_q.shift[0] == $past(st_q.siBit)
			&& st_q.shift[15:1] == $past(st_q.shift[14:0]);
	endproperty
	a_echo: assert property (p_echo) else $error("input not echoed");

	property p_triState;
		csRise |=> !serialOutOe ##1 !serialOutOe || !analog_feedback_pin;
	endproperty
	a_triState: assert property (p_triState) else $error("output not released");

	property p_latchGlobal;
		csRise && frameOk && frameAddr == scsr_pkg::GLOBAL_ADDR
			|=> st_q.glob == $past(st_q.shift[8:0]);
	endproperty
	a_latchGlobal: assert property (p_latchGlobal) else $error("global not latched");

	property p_reject;
		csRise && !frameOk |=> $stable(st_q.sel) && $stable(st_q.glob)
			&& $stable(st_q.prof) && $stable(st_q.wd);
	endproperty
	a_reject: assert property (p_reject) else $error("bad frame changed state");

	property p_selPersist;
		!csRise |=> $stable(st_q.sel);
	endproperty
	a_selPersist: assert property (p_selPersist) else $error("selection moved");

	property p_profOut;
		csRise && frameOk && frameAddr[2:0] == scsr_pkg::PROFILE_SUB
			|=> st_q.prof[$past(st_q.shift[13])] == $past(st_q.shift[8:0]);
	endproperty
	a_profOut: assert property (p_profOut) else $error("profile misrouted");

	property p_dutyDrive;
		dutyDrive |=> switchOn == $past(dutyOn);
	endproperty
	a_dutyDrive: assert property (p_dutyDrive) else $error("duty not driving");

	property p_faultFreeze;
		!analog_feedback_pin && !st_q.csnD |=> $stable(st_q.fault);
	endproperty
	a_faultFreeze: assert property (p_faultFreeze) else $error("fault moved in frame");

	property p_outHold;
		!csFall && !sclkFall |=> $stable(serialOut);
	endproperty
	a_outHold: assert property (p_outHold) else $error("output moved off a clock fall");

	property p_normalFlag;
		csFall |=> st_q.shift[scsr_pkg::NORMAL_BIT];
	endproperty
	a_normalFlag: assert property (p_normalFlag) else $error("normal flag not set");

	property p_wdEcho;
		csRise && frameOk |=> st_q.wd == $past(st_q.shift[scsr_pkg::WATCHDOG_BIT]);
	endproperty
	a_wdEcho: assert property (p_wdEcho) else $error("watchdog bit not kept");

	property p_selLatch;
		csRise && frameOk && frameAddr[2:0] == scsr_pkg::STATUS_SUB
			|=> st_q.sel == $past(st_q.shift[4:0]);
	endproperty
	a_selLatch: assert property (p_selLatch) else $error("selection not latched");

	property p_trimLatch;
		csRise && frameOk && frameAddr == scsr_pkg::TRIM_ADDR
			|=> oscillatorTrim == $past(st_q.shift[8:0]);
	endproperty
	a_trimLatch: assert property (p_trimLatch) else $error("trim not latched");

	property p_countStep;
		sclkRise && !csFall |=> st_q.cnt == $past(st_q.cnt) + 4'h1;
	endproperty
	a_countStep: assert property (p_countStep) else $error("bit count wrong");

	property p_oeHold;
		serialOutOe && !csRise |=> serialOutOe;
	endproperty
	a_oeHold: assert property (p_oeHold) else $error("output dropped in frame");

	property p_directDrive;
		!dutyDrive |=> switchOn == $past(dirS);
	endproperty
	a_directDrive: assert property (p_directDrive) else $error("direct pin ignored");

	property p_failDrive;
		failSafe |=> switchOn == $past(dutyOn);
	endproperty
	a_failDrive: assert property (p_failDrive) else $error("fail-safe not on duty");

	property p_feedbackOne;
		$onehot({feedbackTristate, feedbackCurrent, feedbackTemp});
	endproperty
	a_feedbackOne: assert property (p_feedbackOne) else $error("feedback not one-hot");

	property p_clkSrc;
		!modulationOn |-> !modulationInternalClk;
	endproperty
	a_clkSrc: assert property (p_clkSrc) else $error("clock source while off");

	c_validFrame: cover property (csRise && frameOk);
	c_badFrame:   cover property (csRise && st_q.seen && !frameOk);
	c_chain:      cover property (sclkRise && st_q.cnt == 4'hf ##[1:200] sclkRise);
	c_failSafe:   cover property (failSafe);
endmodule
`default_nettype wire

/* File: scsr_host_model.sv */
// Host model that drives the serial pins of the switch configuration port.
// Assumes clk is the system clock; frames are timed in its cycles.
`timescale 1ns/10ps
`default_nettype none
module scsr_host_model (
	// Clock
	input  wire logic clk,
	// Serial pins
	output var logic  chipSelectN,
	output var logic  spiClk,
	output var logic  serialIn,
	input  wire logic serialOut,
	input  wire logic serialOutOe
);
	localparam int HALF = 20;

	initial begin
		chipSelectN = 1'b1;
		spiClk = 1'b0;
		serialIn = 1'b0;
	end

	task automatic hc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Whole frame, MSB first, clock idle low at both ends
	task automatic frame(input logic [31:0] tx, input int nb, output logic [31:0] rx);
		rx = '0;
		hc(1);
		chipSelectN = 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			serialIn = tx[i];
			hc(HALF);
			rx = {rx[30:0], serialOutOe === 1'b1 ? serialOut : 1'bx};
			spiClk = 1'b1;
			hc(HALF);
			spiClk = 1'b0;
		end
		hc(HALF);
		chipSelectN = 1'b1;
		// Released line shows no stale bit
		serialIn = ~serialIn;
		hc(HALF);
	endtask
endmodule
`default_nettype wire

/* File: switch_config_spi_readback_tb.sv */
// Self-checking bench for the serial configuration slave with readback.
// Assumes scsr_host_model drives the serial pins as the host does.
`timescale 1ns/10ps
`default_nettype none
module switch_config_spi_readback_tb;
	logic                        clk = 1'b0;
	logic                        rst = 1'b1;
	logic                        chipSelectN, spiClk, serialIn, serialOut, serialOutOe;
	logic [1:0][7:0]             faultFlags;
	logic [1:0]                  dutyOn, directIn, switchOn, lampProfileOff;
	logic [1:0]                  highLevelOverride, coolingManagementSelect;
	logic                        supplyLow, failSafe, modulationOn, modulationInternalClk;
	logic                        feedbackTristate, feedbackCurrent, feedbackTemp;
	logic                        feedbackSelValid, feedbackOutputSel, overvoltageGuardOn;
	scsr_pkg::scsr_speed_t [1:0] coolingSpeed, inrushSpeed;
	logic [1:0][1:0]             steadyLimit;
	logic [8:0]                  oscillatorTrim, glob, trim;
	logic [1:0][8:0]             prof;
	logic [4:0]                  sel;
	logic                        wdPrev;
	int                          failures, nTests;
	localparam logic [8:0]       GL [6] = '{9'h1d6, 9'h13e, 9'h02d, 9'h09b, 9'h000, 9'h1d6};
	localparam logic [4:0]       SL [6] = '{5'h14, 5'h1c, 5'h10, 5'h18, 5'h05, 5'h01};

	always #2 clk = ~clk;

	scsr_host_model host (.clk, .chipSelectN, .spiClk, .serialIn, .serialOut, .serialOutOe);

	scsr_spi_readback dut (.clk, .rst, .chipSelectN, .spiClk, .serialIn, .serialOut,
		.serialOutOe, .faultFlags, .dutyOn, .directIn, .supplyLow, .switchOn, .failSafe,
		.lampProfileOff, .coolingSpeed, .inrushSpeed, .highLevelOverride, .steadyLimit,
		.coolingManagementSelect, .modulationOn, .modulationInternalClk, .feedbackTristate,
		.feedbackCurrent, .feedbackTemp, .feedbackSelValid, .feedbackOutputSel,
		.overvoltageGuardOn, .oscillatorTrim);

	task automatic stop_test();
		$display("Mismatches %0d, checks %0d", failures, nTests);
		if (failures == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t serial data %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chkV(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t setting %h, expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [8:0] pd(input logic [8:0] d);
		scsr_pkg::scsr_speed_t cs [4];
		scsr_pkg::scsr_speed_t is [4];
		cs = '{scsr_pkg::SPEED_MEDIUM, scsr_pkg::SPEED_SLOW, scsr_pkg::SPEED_FAST,
			scsr_pkg::SPEED_MEDIUM};
		is = '{scsr_pkg::SPEED_SLOW, scsr_pkg::SPEED_FAST, scsr_pkg::SPEED_MEDIUM,
			scsr_pkg::SPEED_VERY_SLOW};
		return {d[8], cs[d[7:6]], is[d[5:4]], d[3], 2'(d[2:1] + 2'h1), d[0]};
	endfunction

	function automatic logic [15:0] er();
		logic [8:0] p;
		p = 9'h000;
		if (sel[4] && sel[2:0] == 3'h0)
			p = {1'b0, faultFlags[sel[3]]};
		if (sel[4] && sel[2:0] == 3'h4)
			p = prof[sel[3]];
		if (sel == 5'h05)
			p = glob & 9'h1fd;
		return {wdPrev, sel, 1'b1, p};
	endfunction

	task automatic chkAll();
		logic fs;
		fs = glob[8] & supplyLow;
		for (int a = 0; a < 2; a++) begin
			chkV({7'h0, lampProfileOff[a], coolingSpeed[a], inrushSpeed[a],
				highLevelOverride[a], steadyLimit[a], coolingManagementSelect[a]},
				{7'h0, pd(prof[a])});
		end
		chkV({5'h0, modulationOn, modulationInternalClk, feedbackTristate, feedbackCurrent,
			feedbackTemp, feedbackSelValid, feedbackOutputSel, overvoltageGuardOn, failSafe,
			switchOn}, {5'h0, glob[7], glob[7] & glob[6], ~glob[5] & ~glob[4], glob[4],
			glob[5] & ~glob[4], glob[3:2], ~glob[0], fs,
			(fs | glob[7]) ? dutyOn : directIn});
		chkV({7'h0, oscillatorTrim}, {7'h0, trim});
	endtask

	task automatic xf(input logic [31:0] tx, input int nb);
		logic [31:0] rx;
		logic [31:0] ex;
		logic [15:0] e;
		e = er();
		ex = '0;
		for (int i = 0; i < nb; i++) begin
			ex = {ex[30:0], i < 16 ? e[15 - i] : tx[nb + 15 - i]};
		end
		host.frame(tx, nb, rx);
		chkW(rx, ex);
		chkV({15'h0, serialOutOe}, 16'h0);
		if (nb % 16 == 0 && nb > 0) begin
			wdPrev = tx[15];
			if (tx[12:10] == 3'h0)
				sel = tx[4:0];
			if (tx[12:10] == 3'h4)
				prof[tx[13]] = tx[8:0];
			if (tx[14:10] == 5'h05)
				glob = tx[8:0];
			if (tx[14:10] == 5'h07)
				trim = tx[8:0];
		end
		chkAll();
	endtask

	initial begin
		#150000;
		failures++;
		stop_test();
	end

	initial begin
		logic [8:0] p;
		failures = 0;
		nTests = 0;
		faultFlags = {8'h3c, 8'ha5};
		dutyOn = 2'b10;
		directIn = 2'b01;
		supplyLow = 1'b0;
		wdPrev = 1'b0;
		sel = 5'h00;
		prof = '0;
		glob = 9'h000;
		trim = 9'h000;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chkAll();
		for (int k = 0; k < 4; k++) begin
			p = {k[0], k[1:0], k[1:0], k[1], k[1:0], k[0]};
			xf({16'h0, k[0], 2'b10, 3'h4, 1'b0, p}, 16);
			xf({16'h0, ~k[0], 2'b11, 3'h4, 1'b0, ~p}, 16);
		end
		for (int j = 0; j < 6; j++) begin
			xf({16'h0, 1'b1, 10'h000, SL[j]}, 16);
			supplyLow = j[0];
			faultFlags = ~faultFlags;
			xf({16'h0, 1'b0, 5'h05, 1'b0, GL[j]}, 16);
		end
		xf({16'h0, 1'b1, 5'h07, 1'b0, 9'h15a}, 16);
		xf({16'hb5a3, 1'b1, 2'b10, 3'h4, 1'b0, 9'h0a5}, 32);
		xf({8'h00, 8'hff, 16'h915f}, 24);
		xf({24'h0, 8'h91}, 8);
		xf({16'h0, 1'b0, 10'h000, 5'h1c}, 16);
		xf({16'h0, 1'b1, 10'h000, 5'h00}, 16);
		stop_test();
	end
endmodule
`default_nettype wire
